/* File: design/icc_interval_counter_control.sv */
// three-channel 16-bit down-counter timer with control byte and readback
//
// Summary of operation
// - config 0: output low on load, counts while gate high, high at zero.
// - config 0: low gate suspends counting; resumes when gate returns high.
// - config 1: load once; each gate rising edge starts cycle, output low.
// - config 1: gate low keeps counting; new rising edge restarts from loaded count.
// - config 1: output high at zero, held until next gate rising edge.
// - config 4: output high after load, low one input clock at timeout.
// - config 5: gate edge starts timeout; one-clock low strobe; retriggerable.
// - control byte: select 7-6, access 5-4, configuration 3-1, decade bit 0.
// - decade bit 0 gives 16-bit binary, 1 gives four decimal decades.
// - configuration codes 000,001,X10,X11,100,101; top bit ignored for X codes.
// - access 00 latch, 01 low byte, 10 high byte, 11 low then high.
// - low-then-high accesses alternate bytes, tracked by separate read and write toggles.
// - access 00 copies live count into 16-bit hold; counting continues.
// - read after latch returns held value; otherwise live count.
// - select 00,01,10 address counters 0,1,2; 11 means readback command.
// - readback with count-latch bit 0 latches all picked counters together.
// - readback with status-latch bit 0 makes next read return status byte.
// - readback byte: 11, count-latch n, status-latch n, picks 2..0, zero.
// - each pick bit independently includes its counter in readback actions.
// - rate generator: one-clock low every N counts; low gate forces high, reloads.
// - square wave: half high, half low; odd N high (N+1)/2, low (N-1)/2.
// - status byte: output bit 7, null count bit 6, control fields below.
`timescale 1ns/100ps
module icc_interval_counter_control
	import icc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host i/o port
	input wire logic io_cs,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [1:0] io_addr,
	input wire logic [7:0] io_data_in,
	output logic [7:0] io_data_out,
	output logic io_data_oe_n,
	// counter pins
	input wire logic [NUM_CH-1:0] cnt_clk,
	input wire logic [NUM_CH-1:0] cnt_gate,
	output logic [NUM_CH-1:0] cnt_out
);

	typedef struct packed {
		icc_chan_type [NUM_CH-1:0] ch;
		logic [7:0] rdata;
		logic rd_prev;
		logic wr_prev;
	} icc_state_type;

	icc_state_type state_q;
	icc_state_type state_d;

	// x1x codes fold onto the rate and square configurations
	function automatic icc_cfg_type icc_decode(input logic [2:0] cfg);
		logic [2:0] r;
		r = cfg[1] ? {1'b0, cfg[1:0]} : cfg;
		return icc_cfg_type'(r);
	endfunction : icc_decode

	// one count down, binary or four decades
	function automatic logic [15:0] icc_dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic b;
		r = v;
		b = 1'b1;
		if (!bcd) begin
			r = v - CNT_ONE;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (b) begin
					if (r[4*k +: 4] == BCD_ZERO) begin
						r[4*k +: 4] = BCD_NINE;
					end else begin
						r[4*k +: 4] = r[4*k +: 4] - BCD_ONE;
						b = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction : icc_dec

	always_comb begin
		icc_chan_type c;
		icc_cfg_type m;
		logic clk_rise;
		logic gate_rise;
		logic rd_go;
		logic wr_go;
		logic done;
		logic [15:0] old;
		logic [15:0] v;
		logic [1:0] sel;
		c = '0;
		m = CFG_TC;
		clk_rise = 1'b0;
		gate_rise = 1'b0;
		done = 1'b0;
		old = WORD_ZERO;
		v = WORD_ZERO;
		state_d = state_q;
		// one access per strobe: act on its first cycle only
		rd_go = io_cs & io_rd & ~state_q.rd_prev;
		wr_go = io_cs & io_wr & ~state_q.wr_prev;
		sel = io_data_in[SEL_LSB +: 2];
		state_d.rd_prev = io_cs & io_rd;
		state_d.wr_prev = io_cs & io_wr;
		if (rd_go && io_addr == ADDR_CTRL) begin
			state_d.rdata = BYTE_ZERO;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			c = state_q.ch[i];
			m = icc_decode(c.cfg);
			clk_rise = cnt_clk[i] & ~c.clk_prev;
			gate_rise = cnt_gate[i] & ~c.gate_prev;
			c.clk_prev = cnt_clk[i];
			c.gate_prev = cnt_gate[i];
			old = c.cnt;
			done = 1'b0;
			// counting on the counter's own input clock edges
			if (clk_rise) begin
				case (m)
					CFG_TC: begin
						if (c.pend) begin
							c.cnt = c.init;
							c.pend = 1'b0;
							c.null_cnt = 1'b0;
						end else if (cnt_gate[i]) begin
							c.cnt = icc_dec(old, c.bcd);
							if (old == CNT_ONE) begin
								c.out = 1'b1;
							end
						end
					end
					CFG_OS: begin
						if (c.trig) begin
							c.cnt = c.init;
							c.pend = 1'b0;
							c.null_cnt = 1'b0;
							c.trig = 1'b0;
							c.out = 1'b0;
							c.armed = 1'b1;
						end else begin
							c.cnt = icc_dec(old, c.bcd);
							if (c.armed && old == CNT_ONE) begin
								c.out = 1'b1;
								c.armed = 1'b0;
							end
						end
					end
					CFG_RATE: begin
						if (!cnt_gate[i]) begin
							c.out = 1'b1;
						end else if (c.pend || c.trig) begin
							c.cnt = c.init;
							c.pend = 1'b0;
							c.trig = 1'b0;
							c.null_cnt = 1'b0;
							c.out = 1'b1;
						end else if (old == CNT_ONE) begin
							c.cnt = c.init;
							c.out = 1'b1;
						end else begin
							c.cnt = icc_dec(old, c.bcd);
							c.out = (old != CNT_TWO);
						end
					end
					CFG_SQ: begin
						if (!cnt_gate[i]) begin
							c.out = 1'b1;
						end else if (c.pend || c.trig) begin
							c.cnt = c.init;
							c.pend = 1'b0;
							c.trig = 1'b0;
							c.null_cnt = 1'b0;
							c.out = 1'b1;
						end else if (old == CNT_TWO || (old == CNT_THREE && !c.out)) begin
							c.cnt = c.init;
							c.out = ~c.out;
						end else if (old[0]) begin
							// odd count: first edge of a phase evens it out
							c.cnt = icc_dec(old, c.bcd);
							if (!c.out) begin
								c.cnt = icc_dec(icc_dec(c.cnt, c.bcd), c.bcd);
							end
						end else begin
							c.cnt = icc_dec(icc_dec(old, c.bcd), c.bcd);
						end
					end
					CFG_SWS: begin
						c.out = 1'b1;
						if (c.pend) begin
							c.cnt = c.init;
							c.pend = 1'b0;
							c.null_cnt = 1'b0;
							c.armed = 1'b1;
						end else if (cnt_gate[i]) begin
							c.cnt = icc_dec(old, c.bcd);
							if (c.armed && old == CNT_ONE) begin
								c.out = 1'b0;
								c.armed = 1'b0;
							end
						end
					end
					CFG_HWS: begin
						c.out = 1'b1;
						if (c.trig) begin
							c.cnt = c.init;
							c.pend = 1'b0;
							c.null_cnt = 1'b0;
							c.trig = 1'b0;
							c.armed = 1'b1;
						end else begin
							c.cnt = icc_dec(old, c.bcd);
							if (c.armed && old == CNT_ONE) begin
								c.out = 1'b0;
								c.armed = 1'b0;
							end
						end
					end
					default: begin
						c.out = 1'b1;
					end
				endcase
			end
			// control byte and readback command
			if (wr_go && io_addr == ADDR_CTRL) begin
				if (sel == SEL_READBACK) begin
					if (io_data_in[RB_PICK_LSB + i]) begin
						if (!io_data_in[RB_CNT_N_BIT] && !c.held) begin
							c.hold = c.cnt;
							c.held = 1'b1;
							c.rtog = 1'b0;
						end
						if (!io_data_in[RB_STA_N_BIT] && !c.stat_held) begin
							c.stat = {c.out, c.null_cnt, c.af, c.cfg, c.bcd};
							c.stat_held = 1'b1;
						end
					end
				end else if (sel == 2'(i)) begin
					if (io_data_in[AF_LSB +: 2] == AF_LATCH) begin
						if (!c.held) begin
							c.hold = c.cnt;
							c.held = 1'b1;
							c.rtog = 1'b0;
						end
					end else begin
						c.af = io_data_in[AF_LSB +: 2];
						c.cfg = io_data_in[CFG_LSB +: 3];
						c.bcd = io_data_in[BCD_BIT];
						c.wtog = 1'b0;
						c.rtog = 1'b0;
						c.held = 1'b0;
						c.stat_held = 1'b0;
						c.pend = 1'b0;
						c.trig = 1'b0;
						c.armed = 1'b0;
						c.null_cnt = 1'b1;
						c.out = (icc_decode(c.cfg) != CFG_TC);
					end
				end
			end
			// count loads
			if (wr_go && io_addr == 2'(i)) begin
				case (c.af)
					AF_LO: begin
						c.init = {BYTE_ZERO, io_data_in};
						done = 1'b1;
					end
					AF_HI: begin
						c.init = {io_data_in, BYTE_ZERO};
						done = 1'b1;
					end
					AF_LOHI: begin
						if (!c.wtog) begin
							c.lsb_tmp = io_data_in;
						end else begin
							c.init = {io_data_in, c.lsb_tmp};
							done = 1'b1;
						end
						c.wtog = ~c.wtog;
					end
					default: begin
						done = 1'b0;
					end
				endcase
				if (done) begin
					c.pend = 1'b1;
					c.null_cnt = 1'b1;
					if (icc_decode(c.cfg) == CFG_TC) begin
						c.out = 1'b0;
					end
				end
			end
			// counter reads: status first, then held count, else live count
			if (rd_go && io_addr == 2'(i)) begin
				v = c.held ? c.hold : c.cnt;
				if (c.stat_held) begin
					state_d.rdata = c.stat;
					c.stat_held = 1'b0;
				end else begin
					case (c.af)
						AF_HI: begin
							state_d.rdata = v[15:8];
							c.held = 1'b0;
						end
						AF_LOHI: begin
							state_d.rdata = c.rtog ? v[15:8] : v[7:0];
							if (c.rtog) begin
								c.held = 1'b0;
							end
							c.rtog = ~c.rtog;
						end
						default: begin
							state_d.rdata = v[7:0];
							c.held = 1'b0;
						end
					endcase
				end
			end
			// a gate edge in the same cycle as a consume is kept
			if (gate_rise) begin
				c.trig = 1'b1;
			end
			state_d.ch[i] = c;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				state_q.ch[i].af <= AF_RESET;
				state_q.ch[i].cfg <= CFG_RESET;
				state_q.ch[i].null_cnt <= 1'b1;
				// a gate idling high must not look like a trigger after reset
				state_q.ch[i].gate_prev <= 1'b1;
			end
		end else begin
			state_q <= state_d;
		end
	end

	// read data is registered; the bus owns the pins only while reading
	assign io_data_out = state_q.rdata;
	assign io_data_oe_n = ~(io_cs & io_rd);
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			cnt_out[i] = state_q.ch[i].out;
		end
	end

endmodule : icc_interval_counter_control

/* File: design/icc_pkg.sv */
// constants and types for the interval counter control block
package icc_pkg;

	// register addresses on the 8-bit i/o port (offsets +Ch..+Fh)
	localparam logic [1:0] ADDR_CNT0 = 2'h0;
	localparam logic [1:0] ADDR_CNT1 = 2'h1;
	localparam logic [1:0] ADDR_CNT2 = 2'h2;
	localparam logic [1:0] ADDR_CTRL = 2'h3;
	localparam int NUM_CH = 3;

	// control byte field positions
	localparam int SEL_LSB = 6;
	localparam int AF_LSB = 4;
	localparam int CFG_LSB = 1;
	localparam int BCD_BIT = 0;
	// readback command field positions
	localparam int RB_CNT_N_BIT = 5;
	localparam int RB_STA_N_BIT = 4;
	localparam int RB_PICK_LSB = 1;

	// counter select codes
	localparam logic [1:0] SEL_READBACK = 2'h3;

	// access format codes
	localparam logic [1:0] AF_LATCH = 2'h0;
	localparam logic [1:0] AF_LO = 2'h1;
	localparam logic [1:0] AF_HI = 2'h2;
	localparam logic [1:0] AF_LOHI = 2'h3;

	// decoded operating configurations
	typedef enum logic [2:0] {
		CFG_TC = 3'b000,
		CFG_OS = 3'b001,
		CFG_RATE = 3'b010,
		CFG_SQ = 3'b011,
		CFG_SWS = 3'b100,
		CFG_HWS = 3'b101
	} icc_cfg_type;

	// count constants
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_TWO = 16'h0002;
	localparam logic [15:0] CNT_THREE = 16'h0003;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [3:0] BCD_ZERO = 4'h0;
	localparam logic [3:0] BCD_ONE = 4'h1;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [1:0] AF_RESET = 2'h3;

	// per-counter state
	typedef struct packed {
		logic [1:0] af;
		logic [2:0] cfg;
		logic bcd;
		logic [15:0] cnt;
		logic [15:0] init;
		logic [7:0] lsb_tmp;
		logic wtog;
		logic rtog;
		logic [15:0] hold;
		logic held;
		logic [7:0] stat;
		logic stat_held;
		logic null_cnt;
		logic out;
		logic pend;
		logic trig;
		logic armed;
		logic clk_prev;
		logic gate_prev;
	} icc_chan_type;

endpackage : icc_pkg

/* File: testbench/icc_asserts.sv */
// assertions on the interval counter control ports
`timescale 1ns/100ps
module icc_asserts
	import icc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// host port
	input wire logic io_cs,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [1:0] io_addr,
	input wire logic [7:0] io_data_out,
	input wire logic io_data_oe_n,
	// counter pins
	input wire logic [NUM_CH-1:0] cnt_clk,
	input wire logic [NUM_CH-1:0] cnt_gate,
	input wire logic [NUM_CH-1:0] cnt_out
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_rd_take;
		io_cs && io_rd && !$past(io_cs && io_rd);
	endsequence
	sequence s_tick(int n);
		$past(cnt_clk[n]) && !$past(cnt_clk[n], 2);
	endsequence
	// loose on gates: a registered gate edge may land one cycle late
	property p_cause(int n);
		$changed(cnt_out[n]) |-> s_tick(n) or $past(io_cs && io_wr)
			or $past(cnt_gate[n]) != $past(cnt_gate[n], 3);
	endproperty
	a_oe_read_only: assert property (io_data_oe_n == !(io_cs && io_rd))
		else $error("output enable does not follow the read strobe");
	a_rdata_on_take: assert property ($changed(io_data_out) |->
		$past(io_cs && io_rd) && !$past(io_cs && io_rd, 2))
		else $error("read data moved without a new read");
	a_ctrl_reads_zero: assert property (s_rd_take ##0 io_addr == ADDR_CTRL
		|=> io_data_out == BYTE_ZERO)
		else $error("control address read not zero");
	a_read_once: assert property (s_rd_take ##1 (io_cs && io_rd) |=> $stable(io_data_out))
		else $error("held read strobe advanced the data");
	a_write_no_drive: assert property (io_cs && io_wr |-> io_data_oe_n)
		else $error("bus driven during a write");
	a_out0_cause: assert property (p_cause(0))
		else $error("counter 0 output moved without cause");
	a_out1_cause: assert property (p_cause(1))
		else $error("counter 1 output moved without cause");
	a_out2_cause: assert property (p_cause(2))
		else $error("counter 2 output moved without cause");
endmodule : icc_asserts
bind icc_interval_counter_control icc_asserts u_asserts (.ref_clk(ref_clk), .rst(rst),
	.io_cs(io_cs), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
	.io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n), .cnt_clk(cnt_clk),
	.cnt_gate(cnt_gate), .cnt_out(cnt_out));

/* File: testbench/icc_host_model.sv */
// host model driving the counter i/o port
`timescale 1ns/100ps
module icc_host_model (
	// clock
	input wire logic ref_clk,
	// host port
	output logic io_cs,
	output logic io_rd,
	output logic io_wr,
	output logic [1:0] io_addr,
	output logic [7:0] io_data_in,
	input wire logic [7:0] io_data_out
);
	initial begin
		io_cs = 1'b0;
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_addr = 2'h0;
		io_data_in = 8'h00;
	end
	// released lines turn over so stale values never look valid
	task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] v,
		output logic [7:0] q);
		@(posedge ref_clk);
		#1;
		io_addr = a;
		io_data_in = v;
		io_cs = 1'b1;
		io_wr = w;
		io_rd = !w;
		repeat (2) @(posedge ref_clk);
		#1;
		q = io_data_out;
		io_cs = 1'b0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = ~a;
		io_data_in = ~v;
	endtask : acc
endmodule : icc_host_model

/* File: testbench/icc_interval_counter_control_tb.sv */
// testbench for the interval counter control block
`timescale 1ns/100ps
module icc_interval_counter_control_tb
	import icc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic io_cs, io_rd, io_wr, io_data_oe_n;
	logic [1:0] io_addr;
	logic [7:0] io_data_in, io_data_out, d;
	logic [2:0] cnt_clk = 3'h0;
	logic [2:0] cnt_gate = 3'h7;
	logic [2:0] cnt_out;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int h;
	always #2 ref_clk = ~ref_clk;
	icc_interval_counter_control u_dut (.ref_clk(ref_clk), .rst(rst), .io_cs(io_cs),
		.io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_data_in(io_data_in),
		.io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n), .cnt_clk(cnt_clk),
		.cnt_gate(cnt_gate), .cnt_out(cnt_out));
	icc_host_model u_host (.ref_clk(ref_clk), .io_cs(io_cs), .io_rd(io_rd), .io_wr(io_wr),
		.io_addr(io_addr), .io_data_in(io_data_in), .io_data_out(io_data_out));
	task automatic chk(input string s, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", s, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		u_host.acc(1'b1, a, v, d);
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string s);
		u_host.acc(1'b0, a, 8'h00, d);
		chk(s, d, exp);
	endtask : rd
	task automatic tick(input logic [2:0] m, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			cnt_clk = m;
			@(posedge ref_clk);
			#1;
			cnt_clk = 3'h0;
		end
	endtask : tick
	// counts low or unknown outputs of one channel, one look after every tick
	task automatic span(input int c, input int n, output int lows);
		lows = 0;
		repeat (n) begin
			tick(3'h1 << c, 1);
			lows += (cnt_out[c] !== 1'b1);
		end
	endtask : span
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		wr(ADDR_CTRL, 8'h30);
		wr(ADDR_CNT0, 8'h05);
		wr(ADDR_CTRL, 8'h30);
		wr(ADDR_CNT0, 8'h03);
		wr(ADDR_CNT0, 8'h00);
		chk("out0", 8'(cnt_out[0]), 8'h00);
		tick(3'h1, 2);
		wr(ADDR_CTRL, 8'h00);
		tick(3'h1, 1);
		rd(ADDR_CNT0, 8'h02, "latch lo");
		rd(ADDR_CNT0, 8'h00, "latch hi");
		rd(ADDR_CNT0, 8'h01, "live lo");
		rd(ADDR_CNT0, 8'h00, "live hi");
		cnt_gate[0] = 1'b0;
		tick(3'h1, 2);
		cnt_gate[0] = 1'b1;
		chk("out0", 8'(cnt_out[0]), 8'h00);
		tick(3'h1, 3);
		chk("out0", 8'(cnt_out[0]), 8'h01);
		$display("terminal count done");
		wr(ADDR_CTRL, 8'h59);
		wr(ADDR_CNT1, 8'h10);
		chk("out1", 8'(cnt_out[1]), 8'h01);
		tick(3'h2, 2);
		rd(ADDR_CNT1, 8'h09, "decade");
		span(1, 10, h);
		chk("strobe", 8'(h), 8'h01);
		wr(ADDR_CTRL, 8'hE4);
		rd(ADDR_CNT1, 8'h99, "status");
		wr(ADDR_CTRL, 8'hDA);
		tick(3'h7, 1);
		rd(ADDR_CNT1, 8'h98, "unpicked");
		rd(ADDR_CNT0, 8'hFE, "rb lo");
		rd(ADDR_CNT0, 8'hFF, "rb hi");
		$display("strobe and readback done");
		wr(ADDR_CTRL, 8'h20);
		wr(ADDR_CNT0, 8'h01);
		tick(3'h1, 1);
		rd(ADDR_CNT0, 8'h01, "hi load");
		tick(3'h1, 1);
		rd(ADDR_CNT0, 8'h00, "hi read");
		$display("high byte access done");
		cnt_gate[2] = 1'b0;
		wr(ADDR_CTRL, 8'hB2);
		wr(ADDR_CNT2, 8'h02);
		wr(ADDR_CNT2, 8'h00);
		cnt_gate[2] = 1'b1;
		tick(3'h4, 1);
		chk("out2", 8'(cnt_out[2]), 8'h00);
		cnt_gate[2] = 1'b0;
		span(2, 2, h);
		chk("gate low", 8'(h), 8'h01);
		cnt_gate[2] = 1'b1;
		tick(3'h4, 2);
		cnt_gate[2] = 1'b0;
		@(posedge ref_clk);
		#1;
		cnt_gate[2] = 1'b1;
		span(2, 3, h);
		chk("retrig", 8'(h), 8'h02);
		chk("out2", 8'(cnt_out[2]), 8'h01);
		$display("one shot done");
		cnt_gate[1] = 1'b0;
		wr(ADDR_CTRL, 8'h5A);
		wr(ADDR_CNT1, 8'h02);
		span(1, 3, h);
		chk("no trig", 8'(h), 8'h00);
		cnt_gate[1] = 1'b1;
		span(1, 4, h);
		chk("hw strobe", 8'(h), 8'h01);
		wr(ADDR_CTRL, 8'h5C);
		wr(ADDR_CNT1, 8'h03);
		tick(3'h2, 1);
		span(1, 6, h);
		chk("rate", 8'(h), 8'h02);
		tick(3'h2, 1);
		cnt_gate[1] = 1'b0;
		span(1, 3, h);
		chk("gate high", 8'(h), 8'h00);
		cnt_gate[1] = 1'b1;
		span(1, 2, h);
		chk("gate reload", 8'(h), 8'h00);
		wr(ADDR_CTRL, 8'h5E);
		wr(ADDR_CNT1, 8'h05);
		tick(3'h2, 1);
		span(1, 10, h);
		chk("square", 8'(h), 8'h04);
		$display("periodic done");
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CTRL, 8'h50 | 8'(i << 1));
			wr(ADDR_CTRL, 8'hE4);
			u_host.acc(1'b0, ADDR_CNT1, 8'h00, d);
			chk("cfg status", d & 8'h7F, 8'h50 | 8'(i << 1));
		end
		rd(ADDR_CTRL, 8'h00, "ctrl read");
		$display("codes done");
		results();
	end
endmodule : icc_interval_counter_control_tb
